// ===== pin_sync.sv
// two-flop synchroniser for a group of pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] stage;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage   <= '0;
			pin_out <= '0;
		end else begin
			stage   <= pin_in;
			pin_out <= stage;
		end
	end
endmodule
`default_nettype wire

// ===== tof_host.sv
// host model of the serial register port
`timescale 1ns/10ps
`default_nettype none
module tof_host (
	input  wire logic clk,
	input  wire logic sdo,
	output logic      sclk,
	output logic      csl,
	output logic      sdi
);
	initial begin
		sclk = 1'b0;
		csl = 1'b1;
		sdi = 1'b0;
	end
	// 6 clk per phase stays clear of the 4 clk minimum and the pin synchroniser
	task automatic w6;
		repeat (6) @(negedge clk);
	endtask
	task automatic frame(input logic [7:0] c, input logic [23:0] d, input int n, output logic [23:0] r);
		logic [31:0] s;
		s = {c, d};
		r = '0;
		csl = 1'b0;
		for (int i = 0; i < n + 8; i++) begin
			{sdi, s} = {s, 1'b0};
			w6();
			if (i > 7) r = {r[22:0], sdo};
			sclk = 1'b1;
			w6();
			sclk = 1'b0;
		end
		w6();
		csl = 1'b1;
		// a released line shows the inverse, never a held value
		sdi = ~sdi;
		w6();
	endtask
endmodule
`default_nettype wire

// ===== tof_regs_pkg.sv
// constants and types for the stop mask and result register bank
package tof_regs_pkg;
	localparam int ADDR_W = 6;
	localparam int WORD_W = 24;
	localparam logic [ADDR_W-1:0] ADDR_STOP_HIGH    = 6'h08;
	localparam logic [ADDR_W-1:0] ADDR_STOP_LOW     = 6'h09;
	localparam logic [ADDR_W-1:0] ADDR_FINE_FIRST   = 6'h10;
	localparam logic [ADDR_W-1:0] ADDR_TICKS_FIRST  = 6'h11;
	localparam logic [ADDR_W-1:0] ADDR_FINE_SECOND  = 6'h12;
	localparam logic [ADDR_W-1:0] ADDR_TICKS_SECOND = 6'h13;
	localparam logic [7:0]        STOP_LIMIT_RESET  = 8'h00;
	localparam logic [22:0]       RESULT_RESET      = 23'h000000;
	localparam int CMD_AUTO_INC_BIT = 7;
	localparam int CMD_WRITE_BIT    = 6;
	localparam int PARITY_BIT       = 23;
	localparam int TICKS_MSB        = 15;
	localparam int EXT_MSB          = 22;
	localparam int EXT_LSB          = 16;
	localparam logic [2:0] LAST_BIT        = 3'h7;
	localparam logic [1:0] WIDE_LAST_BYTE  = 2'h2;
	localparam logic [1:0] NARROW_LAST_BYTE = 2'h0;
	typedef struct packed {
		logic [22:0] fine_first;
		logic [22:0] ticks_first;
		logic [22:0] fine_second;
		logic [22:0] ticks_second;
	} result_set_t;
	typedef enum logic [1:0] {
		ST_CMD  = 2'b01,
		ST_DATA = 2'b10
	} serial_state_t;
endpackage

// ===== tof_stop_mask_and_result_regs.sv
// serial register port, stop mask and first two result pairs of one channel
//
// Functional notes
// R1: mask upper byte at 08h, RW, resets 00h
// R2: mask lower byte at 09h, RW, resets 00h
// R3: first fine result 10h, 23 bits plus parity
// R4: first tick count 11h, 16 bits plus parity
// R5: tick bits 22-16 zero unless averaging mode
// R6: second fine result 12h, same layout
// R7: second tick count 13h, 16 bits plus parity
// R8: stops ignored until tick count reaches mask
`timescale 1ns/10ps
`default_nettype none
module tof_stop_mask_and_result_regs
	import tof_regs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        serial_clk,
	input  wire logic        channel_select_low,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	input  wire logic        results_load,
	input  wire result_set_t results_in,
	input  wire logic        averaging_mode,
	input  wire logic [15:0] clock_count,
	input  wire logic        stop_event,
	output logic             stop_accepted
);
	logic [2:0]        synced;
	logic              sclk_d;
	serial_state_t     state;
	logic [2:0]        bit_cnt;
	logic [1:0]        byte_cnt;
	logic [7:0]        in_shift;
	logic [ADDR_W-1:0] addr;
	logic              write_mode;
	logic              auto_inc;
	logic [WORD_W-1:0] out_shift;
	logic [7:0]        stop_ignore_limit_high;
	logic [7:0]        stop_ignore_limit_low;
	result_set_t       stored;

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk     (clk),
		.nrst    (nrst),
		// select enters inverted so a reset sync reads as deselected, not as a false frame
		.pin_in  ({serial_clk, ~channel_select_low, serial_data_in}),
		.pin_out (synced)
	);

	wire sclk_s    = synced[2];
	wire sel_low_s = ~synced[1];
	wire din_s     = synced[0];

	function automatic logic is_wide(input logic [ADDR_W-1:0] a);
		is_wide = (a == ADDR_FINE_FIRST) || (a == ADDR_TICKS_FIRST) ||
			(a == ADDR_FINE_SECOND) || (a == ADDR_TICKS_SECOND);
	endfunction

	// parity over the whole word comes out even
	function automatic logic [WORD_W-1:0] with_parity(input logic [22:0] v);
		with_parity = {^v, v};
	endfunction

	// R5: extension bits only survive in averaging mode
	function automatic logic [22:0] ticks_view(input logic [22:0] t, input logic avg);
		ticks_view = avg ? t : {7'h00, t[TICKS_MSB:0]};
	endfunction

	// R1: R2: R3: R4: R6: R7: read decode, unmapped reads as zero
	function automatic logic [WORD_W-1:0] load_word(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_STOP_HIGH:    load_word = {stop_ignore_limit_high, 16'h0000};
			ADDR_STOP_LOW:     load_word = {stop_ignore_limit_low, 16'h0000};
			ADDR_FINE_FIRST:   load_word = with_parity(stored.fine_first);
			ADDR_TICKS_FIRST:  load_word = with_parity(stored.ticks_first);
			ADDR_FINE_SECOND:  load_word = with_parity(stored.fine_second);
			ADDR_TICKS_SECOND: load_word = with_parity(stored.ticks_second);
			default:           load_word = 24'h000000;
		endcase
	endfunction

	wire              sclk_rise = sclk_s & ~sclk_d & ~sel_low_s;
	wire              sclk_fall = ~sclk_s & sclk_d & ~sel_low_s;
	wire [7:0]        next_in   = {in_shift[6:0], din_s};
	wire              byte_done = sclk_rise && (bit_cnt == LAST_BIT);
	wire [ADDR_W-1:0] next_addr = addr + 6'h01;
	wire [1:0]        last_byte = (is_wide(addr) && !write_mode) ? WIDE_LAST_BYTE : NARROW_LAST_BYTE;
	wire              word_done = byte_done && (state == ST_DATA) && (byte_cnt == last_byte);
	wire              wr_strobe = byte_done && (state == ST_DATA) && write_mode;
	wire [15:0]       stop_limit = {stop_ignore_limit_high, stop_ignore_limit_low};

	assign serial_data_oe = ~sel_low_s;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
		end
	end

	// deselect aborts any frame; a word is snapshotted at load so reads never tear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state           <= ST_CMD;
			bit_cnt         <= 3'h0;
			byte_cnt        <= 2'h0;
			in_shift        <= 8'h00;
			addr            <= 6'h00;
			write_mode      <= 1'b0;
			auto_inc        <= 1'b0;
			out_shift       <= 24'h000000;
			serial_data_out <= 1'b0;
		end else if (sel_low_s) begin
			state    <= ST_CMD;
			bit_cnt  <= 3'h0;
			byte_cnt <= 2'h0;
		end else begin
			if (sclk_rise) begin
				in_shift <= next_in;
				bit_cnt  <= bit_cnt + 3'h1;
			end
			if (byte_done) begin
				case (state)
					ST_CMD: begin
						addr       <= next_in[ADDR_W-1:0];
						write_mode <= next_in[CMD_WRITE_BIT];
						auto_inc   <= next_in[CMD_AUTO_INC_BIT];
						byte_cnt   <= 2'h0;
						out_shift  <= load_word(next_in[ADDR_W-1:0]);
						state      <= ST_DATA;
					end
					ST_DATA: begin
						if (word_done) begin
							byte_cnt <= 2'h0;
							if (auto_inc) begin
								addr      <= next_addr;
								out_shift <= load_word(next_addr);
							end else begin
								out_shift <= load_word(addr);
							end
						end else begin
							byte_cnt <= byte_cnt + 2'h1;
						end
					end
					default: begin
						state <= ST_CMD;
					end
				endcase
			end
			if (sclk_fall && (state == ST_DATA)) begin
				serial_data_out <= out_shift[WORD_W-1];
				out_shift       <= {out_shift[WORD_W-2:0], 1'b0};
			end
		end
	end

	// R1: R2: mask byte writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stop_ignore_limit_high <= STOP_LIMIT_RESET;
			stop_ignore_limit_low  <= STOP_LIMIT_RESET;
		end else if (wr_strobe) begin
			if (addr == ADDR_STOP_HIGH) begin
				stop_ignore_limit_high <= next_in;
			end
			if (addr == ADDR_STOP_LOW) begin
				stop_ignore_limit_low <= next_in;
			end
		end
	end

	// R3: R4: R5: R6: R7: result capture from the engine
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stored <= {RESULT_RESET, RESULT_RESET, RESULT_RESET, RESULT_RESET};
		end else if (results_load) begin
			stored.fine_first   <= results_in.fine_first;
			stored.ticks_first  <= ticks_view(results_in.ticks_first, averaging_mode);
			stored.fine_second  <= results_in.fine_second;
			stored.ticks_second <= ticks_view(results_in.ticks_second, averaging_mode);
		end
	end

	// R8: stop gate, zero mask never suppresses
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stop_accepted <= 1'b0;
		end else begin
			stop_accepted <= stop_event && ((stop_limit == 16'h0000) || (clock_count >= stop_limit));
		end
	end
endmodule
`default_nettype wire

// ===== tof_stop_mask_and_result_regs_sva.sv
// port assertions for the register bank
`timescale 1ns/10ps
`default_nettype none
module tof_regs_sva (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        serial_clk,
	input wire logic        channel_select_low,
	input wire logic        serial_data_out,
	input wire logic        serial_data_oe,
	input wire logic [15:0] clock_count,
	input wire logic        stop_event,
	input wire logic        stop_accepted
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_stop_cause: assert property (stop_accepted |-> $past(stop_event))
		else $error("stray accept");
	a_stop_top: assert property (stop_event && clock_count == 16'hFFFF |=> stop_accepted)
		else $error("top count refused");
	a_accept_once: assert property (stop_accepted && !stop_event |=> !stop_accepted)
		else $error("accept held");
	a_oe_on: assert property ((!channel_select_low) [*3] |-> serial_data_oe)
		else $error("oe low");
	a_oe_off: assert property (channel_select_low [*3] |-> !serial_data_oe)
		else $error("oe high");
	a_oe_fall: assert property ($fell(serial_data_oe) |-> $past(channel_select_low))
		else $error("oe fell early");
	a_out_steady: assert property ((serial_clk && !channel_select_low) [*5] |-> $stable(serial_data_out))
		else $error("data moved");
	a_idle_steady: assert property ((channel_select_low && !serial_clk) [*6] |-> $stable(serial_data_out))
		else $error("idle data moved");
	c_stop: cover property (stop_accepted);
	c_frame: cover property ($fell(serial_data_oe));
	c_one: cover property (serial_data_oe && serial_data_out);
endmodule
bind tof_stop_mask_and_result_regs tof_regs_sva sva_i (
	.clk                (clk),
	.nrst               (nrst),
	.serial_clk         (serial_clk),
	.channel_select_low (channel_select_low),
	.serial_data_out    (serial_data_out),
	.serial_data_oe     (serial_data_oe),
	.clock_count        (clock_count),
	.stop_event         (stop_event),
	.stop_accepted      (stop_accepted)
);
`default_nettype wire

// ===== tof_stop_mask_and_result_regs_tb.sv
// register bank bench
`timescale 1ns/10ps
`default_nettype none
module tof_stop_mask_and_result_regs_tb;
	import tof_regs_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        results_load = 1'b0;
	logic        averaging_mode = 1'b0;
	logic        stop_event = 1'b0;
	logic [15:0] clock_count = '0;
	result_set_t results_in = {23'h512345, 23'h7F1234, 23'h000001, 23'h00FFFF};
	logic        serial_clk, channel_select_low, serial_data_in, serial_data_out, serial_data_oe, stop_accepted;
	logic [23:0] got;
	int          n_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #12.5 clk = ~clk;
	tof_stop_mask_and_result_regs dut (
		.clk                (clk),
		.nrst               (nrst),
		.serial_clk         (serial_clk),
		.channel_select_low (channel_select_low),
		.serial_data_in     (serial_data_in),
		.serial_data_out    (serial_data_out),
		.serial_data_oe     (serial_data_oe),
		.results_load       (results_load),
		.results_in         (results_in),
		.averaging_mode     (averaging_mode),
		.clock_count        (clock_count),
		.stop_event         (stop_event),
		.stop_accepted      (stop_accepted)
	);
	tof_host host (.clk, .sdo(serial_data_out), .sclk(serial_clk), .csl(channel_select_low), .sdi(serial_data_in));
	task automatic chk(input string nm, input logic [23:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [23:0] e);
		host.frame({2'b00, a}, 24'hA5A5A5, a < 6'h10 ? 8 : 24, got);
		chk($sformatf("reg %h", a), e, got);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.frame({2'b01, a}, {d, 16'h0}, 8, got);
	endtask
	task automatic load(input logic m);
		averaging_mode = m;
		results_load = 1'b1;
		@(negedge clk);
		results_load = 1'b0;
	endtask
	task automatic stop(input logic [15:0] c, input logic e);
		clock_count = c;
		stop_event = 1'b1;
		@(negedge clk);
		stop_event = 1'b0;
		chk("stop", {23'h0, e}, {23'h0, stop_accepted});
		@(negedge clk);
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		for (int a = 8; a < 20; a++) rd(6'(a), '0);
		wr(ADDR_STOP_HIGH, 8'hA5);
		wr(ADDR_STOP_LOW, 8'h3C);
		wr(ADDR_FINE_FIRST, 8'hFF);
		rd(ADDR_STOP_HIGH, 24'h0000A5);
		rd(ADDR_STOP_LOW, 24'h00003C);
		rd(ADDR_FINE_FIRST, '0);
		load(1'b0);
		// parity is the xor of bits 22..0, worked out by hand
		rd(ADDR_FINE_FIRST, 24'hD12345);
		rd(ADDR_TICKS_FIRST, 24'h801234);
		rd(ADDR_FINE_SECOND, 24'h800001);
		rd(ADDR_TICKS_SECOND, 24'h00FFFF);
		load(1'b1);
		rd(ADDR_TICKS_FIRST, 24'h7F1234);
		// two words in one frame: auto-increment moves on, plain mode repeats the word
		host.frame({2'b10, ADDR_FINE_FIRST}, 24'h000000, 48, got);
		chk("auto inc", 24'h7F1234, got);
		host.frame({2'b00, ADDR_FINE_FIRST}, 24'h000000, 48, got);
		chk("repeat", 24'hD12345, got);
		stop(16'hA53B, 1'b0);
		stop(16'hA53C, 1'b1);
		stop(16'hFFFF, 1'b1);
		wr(ADDR_STOP_HIGH, 8'h00);
		wr(ADDR_STOP_LOW, 8'h00);
		stop(16'h0000, 1'b1);
		wr(ADDR_STOP_HIGH, 8'h5A);
		stop(16'h0000, 1'b0);
		// reset in mid-run must clear the mask and the results again
		nrst = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		rd(ADDR_STOP_HIGH, '0);
		rd(ADDR_FINE_FIRST, '0);
		rd(ADDR_TICKS_FIRST, '0);
		stop(16'h0000, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
